//--- rtl/iouf_fifo.v
// small word fifo with valid/ready on both sides
`timescale 1ns/10ps
module iouf_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clock_in,
    input wire rst_in,
    input wire [WIDTH-1:0] wr_data_in,
    input wire wr_valid_in,
    output wire wr_ready_out,
    output wire [WIDTH-1:0] rd_data_out,
    output wire rd_valid_out,
    input wire rd_ready_in
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;
    assign wr_ready_out = (count != DEPTH[AW:0]);
    assign rd_valid_out = (count != {(AW+1){1'b0}});
    assign rd_data_out = mem[rd_ptr];
    assign push = wr_valid_in & wr_ready_out;
    assign pop = rd_valid_out & rd_ready_in;
    always @(posedge clock_in) begin
        if (push) begin
            mem[wr_ptr] <= wr_data_in;
        end
        if (rst_in) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push & ~pop) begin
                count <= count + {{AW{1'b0}}, 1'b1};
            end else if (pop & ~push) begin
                count <= count - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // iouf_fifo

//--- rtl/iouf_formatter.v
// output unit formatter for gyro, accelerometer and pps fields
//
// Contract
// - average rate output is mean of gyro samples since previous transmission
// - configured low-pass filtering is applied before averaging
// - average rate uses plain rate encoding, 14 fractional bits
// - integrated angle accumulates since reset within [-4,4> and wraps silently
// - integrated angle uses incremental angle encoding
// - g-compensation corrects gyro scale factor and/or bias from accelerometer
// - accelerometer passes optional single-pole low-pass before compensation
// - acceleration is 24-bit two's complement with 19 fractional bits
// - only the 24-bit gyro field is sent as three bytes, most significant first; accel and pps fields are not serialised
// - incremental velocity is 24-bit with 22 fractional bits
// - average acceleration is mean of samples since last transmission
// - integrated velocity accumulates since reset within [-2,2> and wraps
// - integrated velocity uses incremental velocity encoding
// - pps time since detection is two's complement microseconds
// - pps field is 24-bit integer, one microsecond per bit
// - rate is 24-bit degrees per second, 14 fractional bits
// - incremental angle is 24-bit degrees per sample, 21 fractional bits
`timescale 1ns/10ps
`include "iouf_regs.vh"
module iouf_formatter #(
    parameter W = `IOUF_FIELD_W,
    parameter CNT_W = 8,
    parameter FIFO_DEPTH = 4
) (
    input wire clock_in,
    input wire rst_in,
    input wire sample_in,
    input wire signed [W-1:0] gyro_rate_in,
    input wire signed [W-1:0] accel_in,
    input wire [1:0] gyro_unit_in,
    input wire [1:0] accel_unit_in,
    input wire gyro_lpf_bypass_in,
    input wire [`IOUF_LPF_SHIFT_W-1:0] gyro_lpf_shift_in,
    input wire gcomp_enable_in,
    input wire gcomp_lpf_bypass_in,
    input wire [`IOUF_LPF_SHIFT_W-1:0] gcomp_lpf_shift_in,
    input wire signed [W-1:0] gcomp_bias_coef_in,
    input wire signed [W-1:0] gcomp_scale_coef_in,
    input wire accel_unit_ms_in,
    input wire pps_level_in,
    input wire pps_polarity_in,
    input wire transmit_in,
    output reg field_valid_out,
    output reg [W-1:0] gyro_field_out,
    output reg [W-1:0] accel_field_out,
    output reg [W-1:0] pps_field_out,
    output reg [`IOUF_BYTE_W-1:0] byte_out,
    output reg byte_valid_out,
    input wire byte_ready_in,
    output reg busy_out
);
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam US_CYCLES = (`IOUF_US_NS + `IOUF_CLK_NS - 1) / `IOUF_CLK_NS;
    localparam SEND_IDLE = `IOUF_STATE_IDLE;
    localparam SEND_BYTES = `IOUF_STATE_SEND;

    // divide sum by count; count of zero passes the sum through
    function signed [W-1:0] avg_div;
        input signed [W+CNT_W-1:0] sum;
        input [CNT_W-1:0] n;
        reg signed [W+CNT_W-1:0] q;
        begin
            q = (n == {CNT_W{1'b0}}) ? sum : sum / $signed({1'b0, n});
            avg_div = q[W-1:0];
        end
    endfunction

    // ****************************************************************
    // filtering
    // ****************************************************************
    wire signed [W-1:0] gyro_filt;
    wire signed [W-1:0] accel_filt;
    iouf_lpf #(.WIDTH(W)) u_gyro_lpf (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .sample_in(sample_in),
        .bypass_in(gyro_lpf_bypass_in),
        .shift_in(gyro_lpf_shift_in),
        .x_in(gyro_rate_in),
        .y_out(gyro_filt)
    );
    iouf_lpf #(.WIDTH(W)) u_gcomp_lpf (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .sample_in(sample_in),
        .bypass_in(gcomp_lpf_bypass_in),
        .shift_in(gcomp_lpf_shift_in),
        .x_in(accel_in),
        .y_out(accel_filt)
    );

    // ****************************************************************
    // g-compensation
    // ****************************************************************
    // rate' = rate - bias*a - rate*a*scale, scale coefficient q1.23, bias coefficient in rate q.14 per g, a in q.19
    wire signed [2*W-1:0] bias_prod;
    wire signed [2*W-1:0] scale_prod;
    wire signed [2*W-1:0] scale_term;
    wire signed [W-1:0] gyro_comp;
    assign bias_prod = gcomp_bias_coef_in * accel_filt;
    assign scale_prod = gcomp_scale_coef_in * accel_filt;
    assign scale_term = $signed(scale_prod[2*W-1:W-1]) * gyro_filt;
    assign gyro_comp = gcomp_enable_in
        ? gyro_filt - bias_prod[W-1+`IOUF_ACCEL_FRAC:`IOUF_ACCEL_FRAC]
          - scale_term[W-1+`IOUF_ACCEL_FRAC:`IOUF_ACCEL_FRAC]
        : gyro_filt;

    // ****************************************************************
    // averaging and integration
    // ****************************************************************
    reg signed [W+CNT_W-1:0] gyro_sum;
    reg signed [W+CNT_W-1:0] accel_sum;
    reg [CNT_W-1:0] n_samples;
    reg [W-1:0] angle_int;
    reg [W-1:0] vel_int;
    // rate q.14 deg/s times 1/2000 s into q.21 deg: *2^7/2000
    wire signed [W+7:0] angle_step_w;
    wire signed [W-1:0] angle_step;
    // accel q.19 g times 1/2000 s into q.22: *2^3/2000, optional g to m/s
    wire signed [W+7:0] vel_step_gs_w;
    wire signed [W-1:0] vel_step_gs;
    wire signed [2*W-1:0] vel_step_ms_w;
    wire signed [W-1:0] vel_step;
    assign angle_step_w = ($signed({{8{gyro_comp[W-1]}}, gyro_comp}) <<< (`IOUF_ANGLE_FRAC - `IOUF_RATE_FRAC))
        / `IOUF_INT_SAMPLE_HZ;
    assign angle_step = angle_step_w[W-1:0];
    assign vel_step_gs_w = ($signed({{8{accel_in[W-1]}}, accel_in}) <<< (`IOUF_VEL_FRAC - `IOUF_ACCEL_FRAC))
        / `IOUF_INT_SAMPLE_HZ;
    assign vel_step_gs = vel_step_gs_w[W-1:0];
    assign vel_step_ms_w = vel_step_gs * $signed({1'b0, `IOUF_G_TO_MS_Q16});
    assign vel_step = accel_unit_ms_in ? vel_step_ms_w[W+15:16] : vel_step_gs;

    always @(posedge clock_in) begin
        if (rst_in) begin
            gyro_sum <= {(W+CNT_W){1'b0}};
            accel_sum <= {(W+CNT_W){1'b0}};
            n_samples <= {CNT_W{1'b0}};
            angle_int <= {W{1'b0}};
            vel_int <= {W{1'b0}};
        end else begin
            if (sample_in) begin
                angle_int <= angle_int + angle_step;
                vel_int <= vel_int + vel_step;
            end
            if (transmit_in) begin
                gyro_sum <= sample_in ? {{CNT_W{gyro_comp[W-1]}}, gyro_comp} : {(W+CNT_W){1'b0}};
                accel_sum <= sample_in ? {{CNT_W{accel_in[W-1]}}, accel_in} : {(W+CNT_W){1'b0}};
                n_samples <= {{(CNT_W-1){1'b0}}, sample_in};
            end else if (sample_in) begin
                gyro_sum <= gyro_sum + {{CNT_W{gyro_comp[W-1]}}, gyro_comp};
                accel_sum <= accel_sum + {{CNT_W{accel_in[W-1]}}, accel_in};
                n_samples <= n_samples + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ****************************************************************
    // pps time since detection
    // ****************************************************************
    reg [7:0] us_div;
    reg [W-1:0] pps_us;
    reg pps_seen;
    wire pps_match;
    assign pps_match = (pps_level_in == pps_polarity_in);
    always @(posedge clock_in) begin
        if (rst_in) begin
            us_div <= 8'h00;
            pps_us <= {W{1'b0}};
            pps_seen <= 1'b0;
        end else if (pps_match & ~pps_seen) begin
            pps_seen <= 1'b1;
            us_div <= 8'h00;
            pps_us <= {W{1'b0}};
        end else begin
            pps_seen <= pps_match;
            if (us_div == US_CYCLES[7:0] - 8'h01) begin
                us_div <= 8'h00;
                pps_us <= pps_us + {{(W-1){1'b0}}, 1'b1};
            end else begin
                us_div <= us_div + 8'h01;
            end
        end
    end

    // ****************************************************************
    // unit selection
    // ****************************************************************
    reg [W-1:0] next_gyro;
    reg [W-1:0] next_accel;
    always @* begin
        case (gyro_unit_in)
            `IOUF_GYRO_RATE: next_gyro = gyro_comp;
            `IOUF_GYRO_AVG: next_gyro = avg_div(gyro_sum, n_samples);
            `IOUF_GYRO_INCR: next_gyro = angle_step;
            `IOUF_GYRO_INTEG: next_gyro = angle_int;
            default: next_gyro = gyro_comp;
        endcase
        case (accel_unit_in)
            `IOUF_ACC_ACCEL: next_accel = accel_in;
            `IOUF_ACC_INCR: next_accel = vel_step;
            `IOUF_ACC_AVG: next_accel = avg_div(accel_sum, n_samples);
            `IOUF_ACC_INTEG: next_accel = vel_int;
            default: next_accel = accel_in;
        endcase
    end

    // ****************************************************************
    // field capture and byte serialiser
    // ****************************************************************
    wire fifo_wr_ready;
    wire [W-1:0] fifo_rd_data;
    wire fifo_rd_valid;
    reg fifo_rd_ready;
    reg [1:0] state;
    reg [1:0] byte_idx;
    reg [W-1:0] shift_word;
    always @(posedge clock_in) begin
        if (rst_in) begin
            field_valid_out <= 1'b0;
            gyro_field_out <= {W{1'b0}};
            accel_field_out <= {W{1'b0}};
            pps_field_out <= {W{1'b0}};
        end else begin
            field_valid_out <= transmit_in;
            if (transmit_in) begin
                gyro_field_out <= next_gyro;
                accel_field_out <= next_accel;
                pps_field_out <= pps_us;
            end
        end
    end

    iouf_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH), .AW(2)) u_fifo (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .wr_data_in(gyro_field_out),
        .wr_valid_in(field_valid_out),
        .wr_ready_out(fifo_wr_ready),
        .rd_data_out(fifo_rd_data),
        .rd_valid_out(fifo_rd_valid),
        .rd_ready_in(fifo_rd_ready)
    );

    always @* begin
        fifo_rd_ready = (state == SEND_IDLE);
    end

    always @(posedge clock_in) begin
        if (rst_in) begin
            state <= SEND_IDLE;
            byte_idx <= 2'h0;
            shift_word <= {W{1'b0}};
            byte_out <= 8'h00;
            byte_valid_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            busy_out <= ~fifo_wr_ready;
            case (state)
                SEND_IDLE: begin
                    if (fifo_rd_valid) begin
                        shift_word <= {fifo_rd_data[W-9:0], 8'h00};
                        byte_out <= fifo_rd_data[W-1:W-8];
                        byte_valid_out <= 1'b1;
                        byte_idx <= 2'h1;
                        state <= SEND_BYTES;
                    end
                end
                SEND_BYTES: begin
                    if (byte_ready_in) begin
                        if (byte_idx == 2'h3) begin
                            byte_valid_out <= 1'b0;
                            state <= SEND_IDLE;
                        end else begin
                            byte_out <= shift_word[W-1:W-8];
                            shift_word <= {shift_word[W-9:0], 8'h00};
                            byte_idx <= byte_idx + 2'h1;
                        end
                    end
                end
                default: state <= SEND_IDLE;
            endcase
        end
    end
endmodule // iouf_formatter

//--- rtl/iouf_lpf.v
// single-pole low-pass filter, y += (x - y) >> shift
`timescale 1ns/10ps
`include "iouf_regs.vh"
module iouf_lpf #(
    parameter WIDTH = 24
) (
    input wire clock_in,
    input wire rst_in,
    input wire sample_in,
    input wire bypass_in,
    input wire [`IOUF_LPF_SHIFT_W-1:0] shift_in,
    input wire signed [WIDTH-1:0] x_in,
    output reg signed [WIDTH-1:0] y_out
);
    reg signed [WIDTH+7:0] acc;
    wire signed [WIDTH+7:0] x_ext;
    wire signed [WIDTH+7:0] diff;
    assign x_ext = {x_in, 8'h00};
    assign diff = x_ext - acc;
    always @(posedge clock_in) begin
        if (rst_in) begin
            acc <= {(WIDTH+8){1'b0}};
            y_out <= {WIDTH{1'b0}};
        end else if (sample_in) begin
            if (bypass_in) begin
                acc <= x_ext;
                y_out <= x_in;
            end else begin
                acc <= acc + (diff >>> shift_in);
                y_out <= acc[WIDTH+7:8];
            end
        end
    end
endmodule // iouf_lpf

//--- rtl/iouf_regs.vh
// constants for the output unit formatter
`ifndef IOUF_REGS_VH
`define IOUF_REGS_VH
`define IOUF_FIELD_W 24
`define IOUF_BYTE_W 8
`define IOUF_GYRO_RATE 2'h0
`define IOUF_GYRO_AVG 2'h1
`define IOUF_GYRO_INCR 2'h2
`define IOUF_GYRO_INTEG 2'h3
`define IOUF_ACC_ACCEL 2'h0
`define IOUF_ACC_INCR 2'h1
`define IOUF_ACC_AVG 2'h2
`define IOUF_ACC_INTEG 2'h3
`define IOUF_RATE_FRAC 14
`define IOUF_ANGLE_FRAC 21
`define IOUF_ACCEL_FRAC 19
`define IOUF_VEL_FRAC 22
`define IOUF_INT_SAMPLE_HZ 2000
`define IOUF_CLOCK_HZ 25000000
`define IOUF_US_NS 1000
`define IOUF_CLK_NS 40
`define IOUF_G_TO_MS_Q16 24'h09ce80
`define IOUF_LPF_SHIFT_W 5
`define IOUF_SEL_BYTE_W 2
`define IOUF_STATE_IDLE 2'h0
`define IOUF_STATE_SEND 2'h1
`endif

//--- tb/iouf_asserts.sv
// checker on the formatter ports
`timescale 1ns/10ps
`include "iouf_regs.vh"
module iouf_asserts #(
    parameter W = 24
) (
    input wire clock_in,
    input wire rst_in,
    input wire sample_in,
    input wire [1:0] gyro_unit_in,
    input wire [1:0] accel_unit_in,
    input wire transmit_in,
    input wire field_valid_out,
    input wire [W-1:0] gyro_field_out,
    input wire [W-1:0] accel_field_out,
    input wire [`IOUF_BYTE_W-1:0] byte_out,
    input wire byte_valid_out,
    input wire byte_ready_in,
    input wire busy_out
);
    // ****
    // properties
    // ****
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    property p_fv_tx;
        transmit_in |=> field_valid_out;
    endproperty
    a_fv_tx: assert property (p_fv_tx) else $error("no field strobe after transmit");
    property p_hold;
        !field_valid_out && !$past(rst_in) |-> $stable(gyro_field_out) && $stable(accel_field_out);
    endproperty
    a_hold: assert property (p_hold) else $error("field changed between transmissions");
    property p_bhold;
        byte_valid_out && !byte_ready_in |=> byte_valid_out && $stable(byte_out);
    endproperty
    a_bhold: assert property (p_bhold) else $error("byte not held while stalled");
    property p_bstart;
        field_valid_out && !byte_valid_out && !busy_out |-> ##[1:2] byte_valid_out;
    endproperty
    a_bstart: assert property (p_bstart) else $error("serial word not started");
    property p_gavg0;
        transmit_in && $past(transmit_in) && !$past(sample_in) && gyro_unit_in == `IOUF_GYRO_AVG
            && $past(gyro_unit_in) == `IOUF_GYRO_AVG |=> gyro_field_out == 0;
    endproperty
    a_gavg0: assert property (p_gavg0) else $error("empty gyro average not zero");
    property p_aavg0;
        transmit_in && $past(transmit_in) && !$past(sample_in) && accel_unit_in == `IOUF_ACC_AVG
            && $past(accel_unit_in) == `IOUF_ACC_AVG |=> accel_field_out == 0;
    endproperty
    a_aavg0: assert property (p_aavg0) else $error("empty accel average not zero");
    property p_ghold;
        transmit_in && $past(transmit_in) && !sample_in && !$past(sample_in) && !$past(sample_in, 2)
            && gyro_unit_in == `IOUF_GYRO_INTEG && $past(gyro_unit_in) == `IOUF_GYRO_INTEG |=> $stable(gyro_field_out);
    endproperty
    a_ghold: assert property (p_ghold) else $error("angle moved without samples");
    property p_ahold;
        transmit_in && $past(transmit_in) && !sample_in && !$past(sample_in) && !$past(sample_in, 2)
            && accel_unit_in == `IOUF_ACC_INTEG && $past(accel_unit_in) == `IOUF_ACC_INTEG |=> $stable(accel_field_out);
    endproperty
    a_ahold: assert property (p_ahold) else $error("velocity moved without samples");
    c_avg: cover property (transmit_in && gyro_unit_in == `IOUF_GYRO_AVG);
    c_stall: cover property (byte_valid_out && !byte_ready_in);
    c_full: cover property (busy_out && transmit_in);
endmodule // iouf_asserts
bind iouf_formatter iouf_asserts #(.W(W)) iouf_asserts_i (.clock_in, .rst_in, .sample_in, .gyro_unit_in,
    .accel_unit_in, .transmit_in, .field_valid_out, .gyro_field_out, .accel_field_out, .byte_out,
    .byte_valid_out, .byte_ready_in, .busy_out);

//--- tb/iouf_formatter_tb.sv
// self-checking bench for the output unit formatter
`timescale 1ns/10ps
module iouf_formatter_tb;
    // ****
    // signals and instances
    // ****
    typedef struct {logic [23:0] g, a, p; int gm, am, pm;} iouf_exp_t;
    logic clock_in = 0, rst_in = 1, sample_in = 0, transmit_in = 0, stall = 0, glb = 1, clb = 1, gce = 0;
    logic pps_level_in = 0, pps_polarity_in = 1, fv, bv, busy, brdy, wv;
    logic [1:0] gyro_unit_in = 0, accel_unit_in = 0;
    logic [4:0] gls = 0, cls = 0;
    logic [23:0] gyro_rate_in = 0, accel_in = 0, gsc = 0, pg, pa, word, gf, af, pf;
    logic [7:0] bo;
    logic [31:0] seed = 32'hca053df9;
    logic [24:0] sw, sq[$];
    iouf_exp_t fq[$], ce, le;
    int n_errors = 0, checks_done = 0;
    iouf_formatter iouf_formatter_i (.clock_in, .rst_in, .sample_in, .gyro_rate_in, .accel_in, .gyro_unit_in,
        .accel_unit_in, .gyro_lpf_bypass_in(glb), .gyro_lpf_shift_in(gls), .gcomp_enable_in(gce),
        .gcomp_lpf_bypass_in(clb), .gcomp_lpf_shift_in(cls), .gcomp_bias_coef_in(24'h0),
        .gcomp_scale_coef_in(gsc), .accel_unit_ms_in(1'b0), .pps_level_in, .pps_polarity_in, .transmit_in,
        .field_valid_out(fv), .gyro_field_out(gf), .accel_field_out(af), .pps_field_out(pf), .byte_out(bo),
        .byte_valid_out(bv), .byte_ready_in(brdy), .busy_out(busy));
    iouf_host iouf_host_i (.clock_in, .rst_in, .byte_in(bo), .byte_valid_in(bv), .stall_in(stall),
        .byte_ready_out(brdy), .word_out(word), .word_valid_out(wv));
    initial begin
        forever #20 clock_in = ~clock_in;
    end
    // ****
    // helpers
    // ****
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic fail(input string s);
        n_errors++;
        $display("MISMATCH at %0t: %s", $time, s);
    endtask
    task automatic cmp_field(input logic [23:0] got, exp);
        checks_done++;
        if (got !== exp) fail($sformatf("field %h expected %h", got, exp));
    endtask
    task automatic cmp_word(input logic [23:0] got, exp);
        checks_done++;
        if (got !== exp) fail($sformatf("serial word %h expected %h", got, exp));
    endtask
    task automatic cmp_pps(input logic [23:0] got, exp);
        checks_done++;
        if (got !== exp && got !== exp - 24'h1) fail($sformatf("pps time %h expected %h", got, exp));
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    task automatic complete_run();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic drain();
        stall <= 1'b0;
        for (int i = 0; i < 3000 && fq.size() + sq.size() > 0; i++) cyc(1);
        if (fq.size() + sq.size() > 0) begin
            fail("results still pending");
            complete_run();
        end
    endtask
    task automatic smp();
        transmit_in <= 1'b0;
        sample_in <= 1'b1;
        stall <= rnd() > 32'h90000000;
        @(posedge clock_in);
        sample_in <= 1'b0;
        cyc(4);
    endtask
    task automatic tx(input iouf_exp_t e);
        transmit_in <= 1'b1;
        fq.push_back(e);
        if (!busy) sq.push_back({e.gm == 1, e.g});
        @(posedge clock_in);
    endtask
    // one mode pair: settle on constant inputs, then n samples in one window
    task automatic run(input int gm, am, n, input bit filt);
        int k, j;
        iouf_exp_t e;
        k = (n > 8) ? 4000 : $signed(rnd()) % 4000;
        if (filt) k = (k < 0 ? -k : k) + 1;
        j = $signed(rnd()) % 30000;
        gyro_unit_in <= gm[1:0];
        accel_unit_in <= am[1:0];
        gyro_rate_in <= 24'(k * 2000);
        accel_in <= 24'(j * 250);
        glb <= !filt;
        gls <= filt ? 5'h1 : 5'(rnd());
        {clb, cls} <= 6'(rnd());
        repeat (40) smp();
        e.gm = 0;
        e.am = 0;
        e.pm = 0;
        tx(e);
        repeat (n) smp();
        e.g = gm == 2 ? 24'(k * 128) : gm == 3 ? 24'(n * k * 128) : gm == 1 && n == 0 ? 24'h0 : 24'(k * 2000 - filt);
        e.gm = gm == 3 ? 2 : 1;
        e.a = am == 1 ? 24'(j) : am == 3 ? 24'(n * j) : am == 2 && n == 0 ? 24'h0 : 24'(j * 250);
        e.am = am == 3 ? 2 : 1;
        tx(e);
        transmit_in <= 1'b0;
        le = e;
        cyc(4);
    endtask
    // ****
    // result monitor
    // ****
    always @(posedge clock_in) begin
        if (fv && fq.size() == 0) fail("unexpected field strobe");
        else if (fv) begin
            ce = fq.pop_front();
            if (ce.gm == 1) cmp_field(gf, ce.g);
            if (ce.gm == 2) cmp_field(gf - pg, ce.g);
            if (ce.am == 1) cmp_field(af, ce.a);
            if (ce.am == 2) cmp_field(af - pa, ce.a);
            if (ce.pm == 1) cmp_pps(pf, ce.p);
        end
        pg = gf;
        pa = af;
        if (wv && sq.size() == 0) fail("unexpected serial word");
        else if (wv) begin
            sw = sq.pop_front();
            if (sw[24]) cmp_word(word, sw[23:0]);
        end
    end
    // ****
    // main sequence
    // ****
    initial begin
        iouf_exp_t e;
        int k;
        cyc(2);
        rst_in <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            run(m, m, 4, 0);
            if (m != 0) continue;
            stall <= 1'b1;
            repeat (7) begin
                tx(le);
                transmit_in <= 1'b0;
                cyc(5);
            end
            cmp_field({23'h0, busy}, 24'h1);
            drain();
        end
        run(1, 2, 0, 0);
        run(3, 3, 0, 0);
        run(3, 3, 40, 0);
        for (int pol = 0; pol < 2; pol++) begin
            pps_polarity_in <= pol[0];
            pps_level_in <= !pol[0];
            cyc(10);
            pps_level_in <= pol[0];
            cyc(1250);
            e.gm = 0;
            e.am = 0;
            e.pm = 1;
            e.p = 24'h32;
            tx(e);
            transmit_in <= 1'b0;
        end
        drain();
        rst_in <= 1'b1;
        cyc(2);
        rst_in <= 1'b0;
        run(1, 2, 4, 1);
        // scale compensation at half per g with 1 g applied halves the rate
        k = $signed(rnd()) % 4000;
        gce <= 1'b1;
        gsc <= 24'h400000;
        glb <= 1'b1;
        clb <= 1'b1;
        gyro_unit_in <= 2'h0;
        accel_unit_in <= 2'h0;
        gyro_rate_in <= 24'(k * 2000);
        accel_in <= 24'h080000;
        repeat (4) smp();
        e.gm = 1;
        e.am = 1;
        e.pm = 0;
        e.g = 24'(k * 1000);
        e.a = 24'h080000;
        tx(e);
        transmit_in <= 1'b0;
        drain();
        complete_run();
    end
endmodule // iouf_formatter_tb

//--- tb/iouf_host.sv
// host model that takes serial bytes and rebuilds words
`timescale 1ns/10ps
module iouf_host (
    input wire clock_in,
    input wire rst_in,
    input wire [7:0] byte_in,
    input wire byte_valid_in,
    input wire stall_in,
    output wire byte_ready_out,
    output reg [23:0] word_out,
    output reg word_valid_out
);
    reg [1:0] cnt;
    assign byte_ready_out = !stall_in;
    always @(posedge clock_in) begin
        word_valid_out <= 1'b0;
        if (rst_in) begin
            cnt <= 2'h0;
        end else if (byte_valid_in && byte_ready_out) begin
            word_out <= {word_out[15:0], byte_in};
            cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
            word_valid_out <= (cnt == 2'h2);
        end
    end
endmodule // iouf_host
